/* File: asrh_host.sv */
// Host that starts conversions and reads 16-bit frames from the converter
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// R1: Serial clock gated by frame sync
// R2: Frame sync is active high
// R3: Busy falling edge triggers the read
// R4: Exactly sixteen clock pulses per read
// R5: Serial clock held low between transfers
// R6: Missing first leading zero still accepted
// R7: Link clock never above 10 MHz
// R8: One sixteen-bit word per read
// R9: Sample data on each falling edge
// R10: Read only after conversion has finished
// R11: No clocking during a conversion
// R12: Converter sends four zeros then result
// R13: Converter releases data after sixteenth edge
// R14: Clock low when conversion start falls
// R15: Low twelve bits presented with strobe
module asrh_host #(
	parameter int HALF = asrh_pkg::HALF_CYC,
	parameter int BUSY_WAIT = 255,
	parameter int DEPTH = asrh_pkg::FIFO_DEPTH
) (
	input wire logic mclk, // System clock, 20 MHz
	input wire logic rst, // Synchronous reset, high
	input wire logic start, // Request one conversion
	input wire logic auto_run, // Convert back to back
	output logic start_ready, // Sequencer idle
	output logic conversion_start_n, // Conversion start pin
	input wire logic host_interrupt_input, // Busy pin of converter
	output logic host_serial_clock_out, // Gated serial clock pin
	output logic host_frame_sync_out, // Frame sync, high in read
	input wire logic host_data_receive, // Serial data pin
	output logic [asrh_pkg::RESULT_BITS-1:0] result, // Last result
	output logic result_strobe, // One pulse per result
	output logic frame_err, // Leading bits 14:12 not zero
	output logic out_valid, // FIFO word available
	input wire logic out_ready, // FIFO reader accepts
	output logic [asrh_pkg::RESULT_BITS-1:0] out_data // FIFO head
);
	// ****************************************
	// Timing derived from parameters
	// ****************************************
	// Shortest legal half period; a faster setting is raised to it
	localparam int HALF_MIN = (asrh_pkg::LINK_MIN_PERIOD_NS + 2 * asrh_pkg::CLK_PERIOD_NS - 1)
		/ (2 * asrh_pkg::CLK_PERIOD_NS);
	localparam int HALF_USE = (HALF < HALF_MIN) ? HALF_MIN : HALF; // [R7]
	// Timer spends a cycle at zero, so load one less than the half period
	localparam logic [asrh_pkg::TMR_W-1:0] T_HALF = asrh_pkg::TMR_W'(HALF_USE - 1);
	localparam logic [asrh_pkg::TMR_W-1:0] T_BUSY = asrh_pkg::TMR_W'(BUSY_WAIT);
	localparam int ZEROS_TOP = asrh_pkg::FRAME_BITS - 2;
	localparam int ZEROS_BOT = asrh_pkg::RESULT_BITS;

	asrh_pkg::asrh_ctl_t st;
	asrh_pkg::asrh_ctl_t next_st;
	asrh_pkg::asrh_pins_t pins_raw;
	asrh_pkg::asrh_pins_t pins;
	logic fifo_ready;
	logic busy_fall;
	logic tmr_done;

	// ****************************************
	// Pin synchronisation
	// ****************************************
	assign pins_raw.busy = host_interrupt_input;
	assign pins_raw.conv_serial_data_out = host_data_receive;

	asrh_sync #(
		.W($bits(asrh_pkg::asrh_pins_t))
	) u_sync (
		.mclk(mclk),
		.rst(rst),
		.d(pins_raw),
		.q(pins)
	);

	// End of conversion seen as a busy falling edge
	assign busy_fall = st.busy_prev && !pins.busy; // [R3]
	assign tmr_done = st.tmr == asrh_pkg::TMR_ZERO;

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb begin
		next_st = st;
		next_st.busy_prev = pins.busy;
		next_st.strobe = 1'b0;
		if (!tmr_done) begin
			next_st.tmr = st.tmr - asrh_pkg::TMR_ONE;
		end
		unique case (st.state)
			asrh_pkg::ST_IDLE: begin
				next_st.sclk = 1'b0; // [R5]
				next_st.fsync = 1'b0;
				if (start || auto_run) begin
					// Clock is low here, so the bit counter resets cleanly
					next_st.conversion_start_n_n = 1'b0; // [R14]
					next_st.tmr = asrh_pkg::TMR_CONVERSION_START_N;
					next_st.state = asrh_pkg::ST_CONVERSION_START_N;
				end
			end
			asrh_pkg::ST_CONVERSION_START_N: begin
				if (tmr_done) begin
					next_st.conversion_start_n_n = 1'b1;
					next_st.tmr = T_BUSY;
					next_st.state = asrh_pkg::ST_WAIT_HI;
				end
			end
			asrh_pkg::ST_WAIT_HI: begin
				// Short conversions may end before busy is seen high
				if (pins.busy) begin
					next_st.state = asrh_pkg::ST_WAIT_LO;
				end else if (tmr_done) begin
					next_st.state = asrh_pkg::ST_WAIT_LO;
				end
			end
			asrh_pkg::ST_WAIT_LO: begin
				// Link stays quiet during conversion to keep codes tight
				next_st.sclk = 1'b0; // [R11]
				if (busy_fall || !pins.busy) begin // [R10]
					next_st.fsync = 1'b1; // [R2]
					next_st.tmr = T_HALF;
					next_st.bits = asrh_pkg::CNT_ZERO;
					next_st.state = asrh_pkg::ST_LEAD;
				end
			end
			asrh_pkg::ST_LEAD: begin
				if (tmr_done) begin
					next_st.sclk = 1'b1;
					next_st.tmr = T_HALF;
					next_st.state = asrh_pkg::ST_SHIFT;
				end
			end
			asrh_pkg::ST_SHIFT: begin
				if (tmr_done) begin
					if (st.sclk) begin
						// Falling edge: take one bit, MSB first
						next_st.sclk = 1'b0;
						next_st.shreg = {st.shreg[asrh_pkg::FRAME_BITS-2:0],
							pins.conv_serial_data_out}; // [R9] [R12]
						next_st.bits = st.bits + asrh_pkg::CNT_ONE;
						if (st.bits == asrh_pkg::CNT_FRAME - asrh_pkg::CNT_ONE) begin // [R4]
							next_st.state = asrh_pkg::ST_DONE;
						end
					end else begin
						next_st.sclk = 1'b1;
					end
					next_st.tmr = T_HALF;
				end
			end
			asrh_pkg::ST_DONE: begin
				// Data line released by the converter; clock parks low
				next_st.fsync = 1'b0; // [R13] [R5]
				next_st.sclk = 1'b0;
				// Stall here while the FIFO is full
				if (fifo_ready) begin
					next_st.result = st.shreg[asrh_pkg::RESULT_BITS-1:0]; // [R15] [R8]
					next_st.strobe = 1'b1; // [R15]
					// First zero may be lost at speed, so it is not checked
					next_st.frame_err = |st.shreg[ZEROS_TOP:ZEROS_BOT]; // [R6]
					next_st.state = asrh_pkg::ST_IDLE;
				end
			end
			default: begin
				next_st.state = asrh_pkg::ST_IDLE;
			end
		endcase
		// Converter sees the clock only inside a frame
		next_st.sclk_out = next_st.sclk && next_st.fsync; // [R1]
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
			st.state <= asrh_pkg::ST_IDLE;
			st.conversion_start_n_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// ****************************************
	// Result FIFO
	// ****************************************
	asrh_fifo #(
		.WIDTH(asrh_pkg::RESULT_BITS),
		.DEPTH(DEPTH)
	) u_fifo (
		.mclk(mclk),
		.rst(rst),
		.in_valid(st.state == asrh_pkg::ST_DONE),
		.in_ready(fifo_ready),
		.in_data(st.shreg[asrh_pkg::RESULT_BITS-1:0]),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	// ****************************************
	// Outputs
	// ****************************************
	assign start_ready = st.state == asrh_pkg::ST_IDLE;
	assign conversion_start_n = st.conversion_start_n_n;
	assign host_serial_clock_out = st.sclk_out;
	assign host_frame_sync_out = st.fsync;
	assign result = st.result;
	assign result_strobe = st.strobe;
	assign frame_err = st.frame_err;
endmodule
`default_nettype wire

/* File: asrh_pkg.sv */
// Shared constants and types for the converter serial readout host
package asrh_pkg;

	// ****************************************
	// Clock and link timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int LINK_PERIOD_NS = 400;
	localparam int LINK_MAX_HZ = 10_000_000;
	localparam int LINK_MIN_PERIOD_NS = 1_000_000_000 / LINK_MAX_HZ;
	localparam int HALF_CYC = LINK_PERIOD_NS / 2 / CLK_PERIOD_NS;
	localparam int CONVERSION_START_N_LOW_NS = 100;
	localparam int CONVERSION_START_N_LOW_CYC = (CONVERSION_START_N_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS = 16;
	localparam int RESULT_BITS = 12;
	localparam int LEAD_ZEROS = FRAME_BITS - RESULT_BITS;
	localparam int TMR_W = 8;
	localparam int CNT_W = 5;
	localparam int FIFO_DEPTH = 32;

	localparam logic [TMR_W-1:0] TMR_ZERO = 8'h00;
	localparam logic [TMR_W-1:0] TMR_ONE = 8'h01;
	localparam logic [TMR_W-1:0] TMR_HALF = TMR_W'(HALF_CYC);
	localparam logic [TMR_W-1:0] TMR_CONVERSION_START_N = TMR_W'(CONVERSION_START_N_LOW_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [CNT_W-1:0] CNT_FRAME = CNT_W'(FRAME_BITS);

	// ****************************************
	// Sequencer
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CONVERSION_START_N = 3'h1,
		ST_WAIT_HI = 3'h2,
		ST_WAIT_LO = 3'h3,
		ST_LEAD = 3'h4,
		ST_SHIFT = 3'h5,
		ST_DONE = 3'h6
	} asrh_state_t;

	typedef struct packed {
		logic busy;
		logic conv_serial_data_out;
	} asrh_pins_t;

	typedef struct packed {
		asrh_state_t state;
		logic [TMR_W-1:0] tmr;
		logic [CNT_W-1:0] bits;
		logic [FRAME_BITS-1:0] shreg;
		logic sclk;
		logic fsync;
		logic sclk_out;
		logic conversion_start_n_n;
		logic busy_prev;
		logic [RESULT_BITS-1:0] result;
		logic strobe;
		logic frame_err;
	} asrh_ctl_t;

endpackage

/* File: asrh_sync.sv */
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module asrh_sync #(
	parameter int W = 2
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic [W-1:0] d, // Asynchronous inputs
	output logic [W-1:0] q // Synchronised outputs
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} asrh_sync_st_t;

	asrh_sync_st_t st;
	asrh_sync_st_t next_st;

	always_comb begin
		next_st.meta = d;
		next_st.stable = st.meta;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign q = st.stable;
endmodule
`default_nettype wire

/* File: asrh_fifo.sv */
// Result FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module asrh_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset, high
	input wire logic in_valid, // Write request
	output logic in_ready, // Space available
	input wire logic [WIDTH-1:0] in_data, // Write data
	output logic out_valid, // Data available
	input wire logic out_ready, // Reader accepts
	output logic [WIDTH-1:0] out_data // Head word
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
	} asrh_fifo_st_t;

	asrh_fifo_st_t st;
	asrh_fifo_st_t next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;
	logic do_wr;
	logic do_rd;

	assign empty = st.wp == st.rp;
	assign full = (st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign do_wr = in_valid && !full;
	assign do_rd = out_ready && !empty;
	assign out_data = mem[st.rp[AW-1:0]];

	always_comb begin
		next_st = st;
		if (do_wr) begin
			next_st.wp = st.wp + 1'b1;
		end
		if (do_rd) begin
			next_st.rp = st.rp + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
		if (do_wr) begin
			mem[st.wp[AW-1:0]] <= in_data;
		end
	end
endmodule
`default_nettype wire

/* File: asrh_properties.sv */
// Port checks for the readout host
`timescale 1ns/1ns
`default_nettype none
module asrh_properties #(
	parameter int HALF = 4
) (
	input wire logic mclk, // Clock
	input wire logic rst, // Reset
	input wire logic conversion_start_n, // Start pin
	input wire logic host_interrupt_input, // Busy pin
	input wire logic host_serial_clock_out, // Link clock
	input wire logic host_frame_sync_out, // Frame sync
	input wire logic [asrh_pkg::RESULT_BITS-1:0] result, // Result
	input wire logic result_strobe, // Strobe
	input wire logic out_valid // FIFO word
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	logic [4:0] pulses;
	logic [7:0] hi;
	always_ff @(posedge mclk) begin
		if (rst || !host_frame_sync_out) begin
			pulses <= 5'h00;
		end else if ($rose(host_serial_clock_out)) begin
			pulses <= pulses + 5'h01;
		end
		hi <= host_serial_clock_out ? hi + 8'h01 : 8'h00;
	end
	// ****
	// Sequences
	// ****
	sequence conversion_start_n_pulse;
		!conversion_start_n [*3] ##1 conversion_start_n;
	endsequence
	sequence quiet_link;
		!host_frame_sync_out && !host_serial_clock_out;
	endsequence
	clock_gated_a: assert property (host_serial_clock_out |-> host_frame_sync_out)
		else $error("link clock outside frame");
	high_time_a: assert property ($fell(host_serial_clock_out) |-> hi == 8'(HALF))
		else $error("link clock high time wrong");
	pulse_count_a: assert property ($fell(host_frame_sync_out) |-> pulses == 5'h10)
		else $error("pulse count not sixteen");
	conversion_start_n_width_a: assert property ($fell(conversion_start_n) |-> conversion_start_n_pulse)
		else $error("start pulse width wrong");
	conversion_start_n_quiet_a: assert property (!conversion_start_n |-> quiet_link)
		else $error("link active at start");
	busy_quiet_a: assert property (host_interrupt_input |-> quiet_link)
		else $error("link active while busy");
	read_after_a: assert property ($rose(host_frame_sync_out) |-> $past(host_interrupt_input, 2) == 1'b0)
		else $error("read before busy end");
	strobe_pulse_a: assert property (result_strobe |=> !result_strobe)
		else $error("strobe too long");
	result_hold_a: assert property ($changed(result) |-> result_strobe)
		else $error("result moved without strobe");
	strobe_fifo_a: assert property (result_strobe |-> out_valid)
		else $error("result not queued");
endmodule
`default_nettype wire

/* File: asrh_conv_model.sv */
// Behavioural converter on the far side of the link
`timescale 1ns/1ns
`default_nettype none
module asrh_conv_model (
	input wire logic mclk, // System clock
	input wire logic conversion_start_n, // Start pin
	input wire logic sclk, // Link clock
	input wire logic [15:0] word_in, // Lead bits and result
	input wire logic [7:0] conv_cyc, // Conversion length
	output logic busy, // Busy pin
	output logic conv_serial_data_out // Data pin
);
	logic [15:0] word;
	logic armed;
	int cnt;
	initial begin
		busy = 1'b0;
		conv_serial_data_out = 1'b1;
		armed = 1'b0;
		cnt = 16;
	end
	// Bit counter clears only with the link clock low
	always @(negedge conversion_start_n) begin
		armed = 1'b1;
		if (!sclk) cnt = 0;
	end
	// The unknown-to-high step at power up is not a conversion
	always @(posedge conversion_start_n) begin
		if (armed) begin
			word = word_in;
			#2 busy = 1'b1;
			repeat (conv_cyc) @(posedge mclk);
			#2 busy = 1'b0;
		end
	end
	// Lead bits then result, MSB first, one per rise
	always @(posedge sclk) if (cnt < 16) conv_serial_data_out = word[15 - cnt];
	// Released after 16th fall; no pull, so show the inverse
	always @(negedge sclk) begin
		cnt = cnt + 1;
		if (cnt == 16) #20 conv_serial_data_out = ~conv_serial_data_out;
	end
endmodule
`default_nettype wire

/* File: asrh_host_tb_top.sv */
// Self-checking bench for the readout host
`timescale 1ns/1ns
`default_nettype none
module asrh_host_tb_top;
	logic mclk, rst, start, auto_run, out_ready, start_ready, conversion_start_n, churn;
	logic host_interrupt_input, host_serial_clock_out, host_frame_sync_out, host_data_receive;
	logic result_strobe, frame_err, out_valid;
	logic [11:0] result, out_data;
	logic [15:0] word, head;
	logic [15:0] corner[4] = '{16'h0000, 16'h8FFF, 16'h1A5A, 16'h45A5};
	logic [7:0] conv_cyc;
	logic [15:0] conv_q[$], fifo_q[$];
	int errors, check_count, seed, strobes, i;
	asrh_host #(.HALF(4), .BUSY_WAIT(255), .DEPTH(32)) dut (.mclk, .rst, .start, .auto_run,
		.start_ready, .conversion_start_n, .host_interrupt_input, .host_serial_clock_out,
		.host_frame_sync_out, .host_data_receive, .result, .result_strobe, .frame_err,
		.out_valid, .out_ready, .out_data);
	asrh_conv_model conv (.mclk(mclk), .conversion_start_n(conversion_start_n),
		.sclk(host_serial_clock_out), .word_in(word), .conv_cyc(conv_cyc),
		.busy(host_interrupt_input), .conv_serial_data_out(host_data_receive));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#5;
	endtask
	task automatic wait_strobes(input int n);
		int k;
		k = 0;
		while (strobes < n && k < 20000) begin
			tick(1);
			k++;
		end
		check(16'(strobes), 16'(n));
	endtask
	// ****
	// Expectations from latched stimulus
	// ****
	always @(posedge conversion_start_n) if (!rst) conv_q.push_back(word);
	always @(posedge mclk) if (churn) #5 word = 16'($random(seed));
	always @(posedge mclk) begin
		if (result_strobe) begin
			strobes++;
			check({4'h0, result}, {4'h0, conv_q[0][11:0]});
			check({15'h0, frame_err}, {15'h0, |conv_q[0][14:12]});
			fifo_q.push_back(conv_q.pop_front());
		end
		if (out_valid && out_ready) begin
			head = fifo_q.pop_front();
			check({4'h0, out_data}, {4'h0, head[11:0]});
		end
	end
	initial begin
		#3000000;
		errors++;
		stop_test();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		seed = 61908;
		errors = 0;
		check_count = 0;
		strobes = 0;
		churn = 1'b0;
		rst = 1'b1;
		start = 1'b0;
		auto_run = 1'b0;
		out_ready = 1'b1;
		word = 16'h0000;
		conv_cyc = 8'h10;
		tick(4);
		rst = 1'b0;
		for (i = 0; i < 8; i++) begin
			word = i < 4 ? corner[i] : 16'($random(seed));
			conv_cyc = 8'($random(seed) & 63) + 8'h04;
			start = 1'b1;
			tick(1);
			start = 1'b0;
			tick(2);
			check({15'h0, start_ready}, 16'h0000);
			// A start while the start pulse is still low must be ignored
			start = 1'b1;
			tick(1);
			start = 1'b0;
			wait_strobes(i + 1);
			check({15'h0, start_ready}, 16'h0001);
		end
		check(16'(conv_q.size()), 16'h0000);
		$display("single reads done");
		out_ready = 1'b0;
		churn = 1'b1;
		auto_run = 1'b1;
		wait_strobes(40);
		tick(300);
		check(16'(strobes), 16'h0028);
		auto_run = 1'b0;
		i = 0;
		while ((out_valid !== 1'b0 || fifo_q.size() > 0 || conv_q.size() > 0) && i < 20000) begin
			out_ready = 1'($random(seed));
			tick(1);
			i++;
		end
		check(16'(strobes), 16'h0029);
		$display("fill and drain done");
		stop_test();
	end
endmodule
bind asrh_host asrh_properties #(.HALF(HALF)) chk (.mclk, .rst, .conversion_start_n,
	.host_interrupt_input, .host_serial_clock_out, .host_frame_sync_out, .result,
	.result_strobe, .out_valid);
`default_nettype wire
